// >>> logic/scisu_fifo.sv
// Purpose: command fifo between the decoder and the controller link
// Assumes: DEPTH is a power of two
// Notes: show-ahead read; full and empty come from the stored count
`timescale 1ns/100ps
`default_nettype none
module scisu_fifo #(
   parameter int WIDTH = 44,
   parameter int DEPTH = 16,
   parameter int LVL_W = 5
) (
   input wire logic mclk,
   input wire logic sys_rst,
   scisu_fifo_if.store fp
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PTR_W-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
   logic [LVL_W-1:0] count_ff, nxt_count;
   logic doPush, doPop;

   assign fp.inReady = (count_ff != FULL_LVL);
   assign fp.outValid = (count_ff != '0);
   assign fp.outData = mem_ff[rdPtr_ff];
   assign fp.level = count_ff;

   always_comb begin
      doPush = fp.inValid && fp.inReady;
      doPop = fp.outValid && fp.outReady;
      nxt_wrPtr = doPush ? wrPtr_ff + PTR_W'(1) : wrPtr_ff;
      nxt_rdPtr = doPop ? rdPtr_ff + PTR_W'(1) : rdPtr_ff;
      nxt_count = count_ff;
      if (doPush && !doPop) begin
         nxt_count = count_ff + LVL_W'(1);
      end else if (doPop && !doPush) begin
         nxt_count = count_ff - LVL_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
      end
   end

   // Storage needs no reset; only written entries are ever read
   always_ff @(posedge mclk) begin
      if (doPush) begin
         mem_ff[wrPtr_ff] <= fp.inData;
      end
   end
endmodule
`default_nettype wire

// >>> logic/scisu_fifo_if.sv
// Purpose: carries fill and drain handshakes between the unit and its command fifo
// Assumes: same clock on both sides
// Notes: level reports stored words
`timescale 1ns/100ps
`default_nettype none
interface scisu_fifo_if #(parameter int WIDTH = 44, parameter int LVL_W = 5);
   logic inValid;
   logic inReady;
   logic [WIDTH-1:0] inData;
   logic outValid;
   logic outReady;
   logic [WIDTH-1:0] outData;
   logic [LVL_W-1:0] level;
   modport user (output inValid, inData, outReady, input inReady, outValid, outData, level);
   modport store (input inValid, inData, outReady, output inReady, outValid, outData, level);
endinterface
`default_nettype wire

// >>> logic/scisu_pkg.sv
// Purpose: shared constants and types for the stream controller issue unit
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes: command word layout is kind, selector, format flag, data
package scisu_pkg;
   localparam int SCISU_DATA_W = 37;
   localparam int SCISU_DEPTH = 32;
   localparam int SCISU_ADDR_W = 5;
   localparam int SCISU_FIFO_DEPTH = 16;
   localparam int SCISU_FIFO_LVL_W = 5;
   // Instruction field positions
   localparam int SCISU_ADDR_HI = 9;
   localparam int SCISU_ADDR_LO = 5;
   localparam int SCISU_DIR_BIT = 4;
   localparam int SCISU_SEL_HI = 3;
   localparam int SCISU_SEL_LO = 1;
   // Selector codes
   localparam logic [2:0] SCISU_SEL_NOOP = 3'h0;
   localparam logic [2:0] SCISU_SEL_RD_LO = 3'h1;
   localparam logic [2:0] SCISU_SEL_RD_HI = 3'h4;
   localparam logic [2:0] SCISU_SEL_FULL_RST = 3'h6;
   localparam logic [2:0] SCISU_SEL_LINK_RST = 3'h7;
   localparam logic [2:0] SCISU_SEL_WR_HEAD5 = 3'h0;
   localparam logic [2:0] SCISU_SEL_WR_HEAD6 = 3'h7;
   // Fifo level at which the processor is held, two slots kept for the stage and the registered hold
   localparam logic [4:0] SCISU_HOLD_LEVEL = 5'h0E;
   typedef enum logic [2:0] {
      SCISU_KIND_NONE = 3'h0,
      SCISU_KIND_READ = 3'h1,
      SCISU_KIND_WRITE = 3'h2,
      SCISU_KIND_CTRL = 3'h3,
      SCISU_KIND_FULL_RST = 3'h4,
      SCISU_KIND_LINK_RST = 3'h5
   } scisu_kind_type;
   localparam int SCISU_CMD_W = 3 + 3 + 1 + SCISU_DATA_W;
endpackage

// >>> logic/scisu_top.sv
// Purpose: issue unit that sends staged words and commands to a stream controller
// Assumes: controller logic runs on mclk, so its handshakes need no synchroniser
// Notes: one instruction taken per cycle in fast mode while procHold_ff is low
// Operation
// - Staging memory holds 32 words of 37 bits
// - Staging filled in slow mode, sent in fast
// - Entry address bits 9:5, opcode in low bits
// - No-operation code issues and changes nothing
// - Read head 1-4 selected, command only, no data; the code still reads the addressed entry and sends it on cmdData_ff
// - Processor stalls while controller holds read
// - Write head: selector 000 head 5, 111 head 6
// - Control write sends entry to FIFO 1-6 register
// - Control words go in pairs, A then B
// - Full reset of the controller offered
// - Separate reset of link communication state
// - Link reset makes controller expect format A
`timescale 1ns/100ps
`default_nettype none
module scisu_stage_mem
   import scisu_pkg::*;
(
   input wire logic mclk,
   input wire logic wrEn,
   input wire logic [SCISU_ADDR_W-1:0] wrAddr,
   input wire logic [SCISU_DATA_W-1:0] wrData,
   input wire logic rdEn,
   input wire logic [SCISU_ADDR_W-1:0] rdAddr,
   output logic [SCISU_DATA_W-1:0] rdData_ff
);
   logic [SCISU_DATA_W-1:0] mem_ff [SCISU_DEPTH];

   // No reset: entries are loaded in slow mode before any fast-mode send
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         mem_ff[wrAddr] <= wrData;
      end
   end

   // Registered read keeps the store a plain synchronous memory
   always_ff @(posedge mclk) begin
      if (rdEn) begin
         rdData_ff <= mem_ff[rdAddr];
      end
   end
endmodule

module scisu_top
   import scisu_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic fastMode,
   input wire logic stageWrEn,
   input wire logic [SCISU_ADDR_W-1:0] stageWrAddr,
   input wire logic [SCISU_DATA_W-1:0] stageWrData,
   input wire logic instrValid,
   input wire logic [9:1] instrField,
   input wire logic ctrlReady,
   input wire logic ctrlHold,
   output logic procHold_ff,
   output logic cmdValid_ff,
   output scisu_kind_type cmdKind_ff,
   output logic [2:0] cmdSel_ff,
   output logic cmdFmtB_ff,
   output logic [SCISU_DATA_W-1:0] cmdData_ff
);
   logic stageWr;
   logic stageRdEn;
   logic [SCISU_DATA_W-1:0] stageRd_ff;
   logic stgValid_ff, nxt_stgValid;
   scisu_kind_type stgKind_ff, nxt_stgKind;
   logic [2:0] stgSel_ff, nxt_stgSel;
   logic fmtB_ff, nxt_fmtB;
   logic readWait_ff, nxt_readWait;
   logic nxt_procHold;
   logic nxt_cmdValid;
   scisu_kind_type nxt_cmdKind;
   logic [2:0] nxt_cmdSel;
   logic nxt_cmdFmtB;
   logic [SCISU_DATA_W-1:0] nxt_cmdData;
   logic accept;
   scisu_kind_type decKind;
   logic [2:0] decSel;
   logic [SCISU_ADDR_W-1:0] decAddr;
   logic [2:0] fieldSel;
   logic loadOut;
   logic pipeEmpty;

   scisu_fifo_if #(.WIDTH(SCISU_CMD_W), .LVL_W(SCISU_FIFO_LVL_W)) cmdQ ();

   scisu_fifo #(
      .WIDTH(SCISU_CMD_W),
      .DEPTH(SCISU_FIFO_DEPTH),
      .LVL_W(SCISU_FIFO_LVL_W)
   ) cmdFifo (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .fp(cmdQ)
   );

   scisu_stage_mem stageStore (
      .mclk(mclk),
      .wrEn(stageWr),
      .wrAddr(stageWrAddr),
      .wrData(stageWrData),
      .rdEn(stageRdEn),
      .rdAddr(decAddr),
      .rdData_ff(stageRd_ff)
   );

   // Staging store, written only while the processor runs slow
   assign stageWr = stageWrEn && !fastMode;
   // A no-operation must not even disturb the read register
   assign stageRdEn = accept && (decKind != SCISU_KIND_NONE);

   // Opcode decode
   always_comb begin
      decAddr = instrField[SCISU_ADDR_HI:SCISU_ADDR_LO];
      fieldSel = instrField[SCISU_SEL_HI:SCISU_SEL_LO];
      decSel = fieldSel;
      decKind = SCISU_KIND_NONE;
      if (instrField[SCISU_DIR_BIT]) begin
         if (fieldSel >= SCISU_SEL_RD_LO && fieldSel <= SCISU_SEL_RD_HI) begin
            decKind = SCISU_KIND_READ;
         end else if (fieldSel == SCISU_SEL_FULL_RST) begin
            decKind = SCISU_KIND_FULL_RST;
         end else if (fieldSel == SCISU_SEL_LINK_RST) begin
            decKind = SCISU_KIND_LINK_RST;
         end else begin
            decKind = SCISU_KIND_NONE;
         end
      end else begin
         // Head writes own codes 000 and 111, control writes 001 to 110
         if (fieldSel == SCISU_SEL_WR_HEAD5 || fieldSel == SCISU_SEL_WR_HEAD6) begin
            decKind = SCISU_KIND_WRITE;
         end else begin
            decKind = SCISU_KIND_CTRL;
         end
      end
   end

   // The stage waits one cycle for the store read; it drains into the fifo
   always_comb begin
      accept = instrValid && fastMode && !procHold_ff
         && (!stgValid_ff || cmdQ.inReady);
      cmdQ.inValid = stgValid_ff;
      cmdQ.inData = {stgKind_ff, stgSel_ff, fmtB_ff, stageRd_ff};
      nxt_stgValid = stgValid_ff && !cmdQ.inReady;
      nxt_stgKind = stgKind_ff;
      nxt_stgSel = stgSel_ff;
      nxt_fmtB = fmtB_ff;
      if (stgValid_ff && cmdQ.inReady) begin
         // Pair tracker advances as each control word leaves the stage
         if (stgKind_ff == SCISU_KIND_CTRL) begin
            nxt_fmtB = !fmtB_ff;
         end else if (stgKind_ff == SCISU_KIND_LINK_RST
            || stgKind_ff == SCISU_KIND_FULL_RST) begin
            nxt_fmtB = 1'b0;
         end
      end
      // A no-operation is never staged, so nothing downstream moves
      if (accept && decKind != SCISU_KIND_NONE) begin
         nxt_stgValid = 1'b1;
         nxt_stgKind = decKind;
         nxt_stgSel = decSel;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stgValid_ff <= 1'b0;
         stgKind_ff <= SCISU_KIND_NONE;
         stgSel_ff <= 3'h0;
         fmtB_ff <= 1'b0;
      end else begin
         stgValid_ff <= nxt_stgValid;
         stgKind_ff <= nxt_stgKind;
         stgSel_ff <= nxt_stgSel;
         fmtB_ff <= nxt_fmtB;
      end
   end

   // Output register toward the controller, refilled when it takes a word
   always_comb begin
      cmdQ.outReady = !cmdValid_ff || ctrlReady;
      loadOut = cmdQ.outReady;
      nxt_cmdValid = cmdValid_ff;
      nxt_cmdKind = cmdKind_ff;
      nxt_cmdSel = cmdSel_ff;
      nxt_cmdFmtB = cmdFmtB_ff;
      nxt_cmdData = cmdData_ff;
      if (loadOut) begin
         nxt_cmdValid = cmdQ.outValid;
         if (cmdQ.outValid) begin
            nxt_cmdKind = scisu_kind_type'(cmdQ.outData[SCISU_CMD_W-1 -: 3]);
            nxt_cmdSel = cmdQ.outData[SCISU_CMD_W-4 -: 3];
            nxt_cmdFmtB = cmdQ.outData[SCISU_DATA_W];
            nxt_cmdData = cmdQ.outData[SCISU_DATA_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cmdValid_ff <= 1'b0;
         cmdKind_ff <= SCISU_KIND_NONE;
         cmdSel_ff <= 3'h0;
         cmdFmtB_ff <= 1'b0;
         cmdData_ff <= '0;
      end else begin
         cmdValid_ff <= nxt_cmdValid;
         cmdKind_ff <= nxt_cmdKind;
         cmdSel_ff <= nxt_cmdSel;
         cmdFmtB_ff <= nxt_cmdFmtB;
         cmdData_ff <= nxt_cmdData;
      end
   end

   // Hold logic: a read keeps the processor stopped until it has left
   // the unit and the controller lets go; the fifo level hold is early by
   // two words because the hold output is itself a register.
   always_comb begin
      pipeEmpty = !stgValid_ff && !cmdQ.outValid && !cmdValid_ff;
      nxt_readWait = readWait_ff;
      if (accept && decKind == SCISU_KIND_READ) begin
         nxt_readWait = 1'b1;
      end else if (readWait_ff && pipeEmpty && !ctrlHold) begin
         nxt_readWait = 1'b0;
      end
      nxt_procHold = nxt_readWait || ctrlHold
         || (cmdQ.level >= SCISU_HOLD_LEVEL);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         readWait_ff <= 1'b0;
         procHold_ff <= 1'b0;
      end else begin
         readWait_ff <= nxt_readWait;
         procHold_ff <= nxt_procHold;
      end
   end
endmodule
`default_nettype wire

// >>> verification/scisu_ctrl_model.sv
// Purpose: stream controller stand-in
// Assumes: shares mclk with the unit
// Notes: slowMode takes one word in eight so the fifo fills
`timescale 1ns/100ps
`default_nettype none
module scisu_ctrl_model
   import scisu_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic slowMode,
   input wire logic cmdValid_ff,
   input wire scisu_kind_type cmdKind_ff,
   output logic ctrlReady,
   output logic ctrlHold
);
   logic [1:0] holdCnt = 2'h0;
   logic [2:0] cyc = 3'h0;
   initial ctrlReady = 1'b0;
   initial ctrlHold = 1'b0;
   // A head read of fifos 1 to 4 keeps the processor waiting a while
   always @(posedge mclk) begin
      if (sys_rst) holdCnt <= 2'h0;
      else if (cmdValid_ff && ctrlReady && cmdKind_ff == SCISU_KIND_READ) holdCnt <= 2'h3;
      else if (holdCnt != 2'h0) holdCnt <= holdCnt - 2'h1;
   end
   always @(negedge mclk) begin
      cyc <= cyc + 3'h1;
      ctrlHold <= holdCnt != 2'h0;
      ctrlReady <= !slowMode || cyc == 3'h0;
   end
endmodule
`default_nettype wire

// >>> verification/scisu_top_assertions.sv
// Purpose: port checks for scisu_top
// Assumes: one clock, synchronous reset
// Notes: format flag is tracked in issue order
`timescale 1ns/100ps
`default_nettype none
module scisu_top_assertions
   import scisu_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic fastMode,
   input wire logic instrValid,
   input wire logic [9:1] instrField,
   input wire logic ctrlReady,
   input wire logic ctrlHold,
   input wire logic procHold_ff,
   input wire logic cmdValid_ff,
   input wire scisu_kind_type cmdKind_ff,
   input wire logic [2:0] cmdSel_ff,
   input wire logic cmdFmtB_ff,
   input wire logic [SCISU_DATA_W-1:0] cmdData_ff
);
   logic expFmt_ff;
   logic nxt_expFmt;
   wire logic took = cmdValid_ff && ctrlReady;
   always_comb begin
      nxt_expFmt = expFmt_ff;
      if (took && cmdKind_ff == SCISU_KIND_CTRL) begin
         nxt_expFmt = !expFmt_ff;
      end else if (took && cmdKind_ff inside {SCISU_KIND_FULL_RST, SCISU_KIND_LINK_RST}) begin
         nxt_expFmt = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      expFmt_ff <= sys_rst ? 1'b0 : nxt_expFmt;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   cmd_stands_a: assert property (cmdValid_ff && !ctrlReady |=> cmdValid_ff
      && $stable(cmdData_ff) && $stable(cmdKind_ff)) else $error("command dropped");
   hold_follow_a: assert property ($rose(ctrlHold) |=> procHold_ff)
      else $error("no stall on hold");
   read_stall_a: assert property (instrValid && fastMode && !procHold_ff
      && instrField[4:1] inside {[4'h9:4'hC]} |=> procHold_ff) else $error("read no stall");
   kind_known_a: assert property (cmdValid_ff |-> cmdKind_ff != SCISU_KIND_NONE)
      else $error("empty command");
   read_sel_a: assert property (cmdValid_ff && cmdKind_ff == SCISU_KIND_READ
      |-> cmdSel_ff inside {[3'h1:3'h4]}) else $error("bad read head");
   wr_sel_a: assert property (cmdValid_ff && cmdKind_ff == SCISU_KIND_WRITE
      |-> cmdSel_ff inside {3'h0, 3'h7}) else $error("bad write head");
   ctrl_sel_a: assert property (cmdValid_ff && cmdKind_ff == SCISU_KIND_CTRL
      |-> cmdSel_ff inside {[3'h1:3'h6]}) else $error("bad control fifo");
   fmt_order_a: assert property (cmdValid_ff && cmdKind_ff == SCISU_KIND_CTRL
      |-> cmdFmtB_ff == expFmt_ff) else $error("format order");
endmodule
bind scisu_top scisu_top_assertions chk (.mclk, .sys_rst, .fastMode, .instrValid, .instrField,
   .ctrlReady, .ctrlHold, .procHold_ff, .cmdValid_ff, .cmdKind_ff, .cmdSel_ff, .cmdFmtB_ff,
   .cmdData_ff);
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: self-checking bench for scisu_top
// Assumes: commands leave in issue order
// Notes: expected words built per instruction
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t: got %0h want %0h", $time, (a), (b)); end end
module tb_top;
   import scisu_pkg::*;
   typedef struct {scisu_kind_type kind; logic [2:0] sel; logic fmt; logic [36:0] data;} scisu_exp_type;
   logic mclk = 1'b0, sys_rst = 1'b1, fastMode = 1'b0, stageWrEn = 1'b0, instrValid = 1'b0;
   logic slowMode = 1'b0, fmt = 1'b0;
   logic [4:0] stageWrAddr = 5'h00;
   logic [36:0] stageWrData = 37'h0;
   logic [9:1] instrField = 9'h000;
   logic ctrlReady, ctrlHold, procHold_ff, cmdValid_ff, cmdFmtB_ff;
   logic [2:0] cmdSel_ff;
   logic [36:0] cmdData_ff;
   scisu_kind_type cmdKind_ff;
   int num_errors = 0, check_count = 0, cycles = 0;
   logic [31:0] rnd = 32'h00012730;
   logic [36:0] stage [32];
   scisu_exp_type expq [$];
   scisu_exp_type got;
   logic [8:0] corner [16] = '{9'h030, 9'h1F7, 9'h021, 9'h031, 9'h006, 9'h00F, 9'h042, 9'h053,
      9'h0FE, 9'h064, 9'h075, 9'h009, 9'h01A, 9'h02B, 9'h03C, 9'h008};
   always #50 mclk = !mclk;
   scisu_top dut (.mclk, .sys_rst, .fastMode, .stageWrEn, .stageWrAddr, .stageWrData, .instrValid,
      .instrField, .ctrlReady, .ctrlHold, .procHold_ff, .cmdValid_ff, .cmdKind_ff, .cmdSel_ff,
      .cmdFmtB_ff, .cmdData_ff);
   scisu_ctrl_model model (.mclk, .sys_rst, .slowMode, .cmdValid_ff, .cmdKind_ff, .ctrlReady,
      .ctrlHold);
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic scisu_exp_type predict(input logic [9:1] f);
      scisu_exp_type e;
      e.sel = f[3:1];
      e.data = stage[f[9:5]];
      e.fmt = 1'b0;
      case (f[4:1])
         4'h8, 4'hD: e.kind = SCISU_KIND_NONE;
         4'h9, 4'hA, 4'hB, 4'hC: e.kind = SCISU_KIND_READ;
         4'hE: e.kind = SCISU_KIND_FULL_RST;
         4'hF: e.kind = SCISU_KIND_LINK_RST;
         4'h0, 4'h7: e.kind = SCISU_KIND_WRITE;
         default: e.kind = SCISU_KIND_CTRL;
      endcase
      return e;
   endfunction
   task automatic send(input logic [9:1] f);
      scisu_exp_type e;
      e = predict(f);
      @(negedge mclk);
      while (procHold_ff !== 1'b0) begin
         instrValid = 1'b0;
         @(negedge mclk);
      end
      instrValid = 1'b1;
      instrField = f;
      e.fmt = fmt;
      if (e.kind == SCISU_KIND_CTRL) fmt = !fmt;
      if (e.kind inside {SCISU_KIND_FULL_RST, SCISU_KIND_LINK_RST}) fmt = 1'b0;
      if (e.kind != SCISU_KIND_NONE) expq.push_back(e);
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      if (!sys_rst && cmdValid_ff === 1'b1 && ctrlReady === 1'b1) begin
         `CHK(expq.size() != 0, 1'b1)
         if (expq.size() != 0) begin
            got = expq.pop_front();
            `CHK(cmdKind_ff, got.kind)
            `CHK(cmdSel_ff, got.sel)
            if (got.kind inside {SCISU_KIND_WRITE, SCISU_KIND_CTRL}) `CHK(cmdData_ff, got.data)
            if (got.kind == SCISU_KIND_CTRL) `CHK(cmdFmtB_ff, got.fmt)
         end
      end
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         $display("Error %0t: timeout", $time);
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(negedge mclk);
      sys_rst = 1'b0;
      for (int i = 0; i < 32; i++) begin
         @(negedge mclk);
         stageWrEn = 1'b1;
         stageWrAddr = i[4:0];
         stageWrData = {rnd[4:0], rnd};
         stage[i] = stageWrData;
         rnd = lfsr(rnd);
      end
      @(negedge mclk);
      stageWrEn = 1'b0;
      // Instruction in slow mode must be dropped, not queued
      instrValid = 1'b1;
      instrField = 9'h030;
      repeat (3) @(negedge mclk);
      instrValid = 1'b0;
      fastMode = 1'b1;
      stageWrEn = 1'b1;
      stageWrData = ~stage[3];
      stageWrAddr = 5'h03;
      foreach (corner[i]) send(corner[i]);
      send(9'h00D);
      stageWrEn = 1'b0;
      slowMode = 1'b1;
      repeat (120) begin
         rnd = lfsr(rnd);
         send(rnd[8:0]);
      end
      @(negedge mclk);
      instrValid = 1'b0;
      for (int i = 0; i < 400 && expq.size() != 0; i++) @(negedge mclk);
      repeat (8) @(negedge mclk);
      `CHK(expq.size(), 0)
      `CHK(procHold_ff, 1'b0)
      tally_and_finish();
   end
endmodule
`undef CHK
`default_nettype wire
